// >>> rtl/ipr_pkg.sv
// Purpose: constants and types for the priority register bank 4 to 8
// Assumes: 16-bit registers on a plain strobe port, word indices 0 to 4
// Notes:   each field is three bits; zero means the source is disabled
// How it works
// - Field code 111 gives its source level seven, the highest.
// - Code 001 gives level one; codes two to six map directly.
// - A zero field disables its source; no request leaves.
// - Unimplemented bits read zero and ignore writes.
// - Every field resets to 100, level four, and is read/write.
// - Register 5: capture8, capture7, converter2, ext_irq1 fields.
// - Register 6: timer4, compare4, compare3, xfer_chan2 fields.
// - Register 7: serial2 tx, serial2 rx, ext_irq2, timer5 fields.
// - Register 8: can1 event, can1 rx ready, spi2 event, spi2 error.
package ipr_pkg;
    localparam int          IPR_ADDR_W    = 3;
    localparam int          IPR_NSRC      = 19;
    localparam logic [2:0]  IPR_IDX_CTRL4 = 3'h0;
    localparam logic [2:0]  IPR_IDX_CTRL5 = 3'h1;
    localparam logic [2:0]  IPR_IDX_CTRL6 = 3'h2;
    localparam logic [2:0]  IPR_IDX_CTRL7 = 3'h3;
    localparam logic [2:0]  IPR_IDX_CTRL8 = 3'h4;
    localparam logic [2:0]  IPR_LVL_RST   = 3'h4;
    localparam logic [2:0]  IPR_LVL_OFF   = 3'h0;
    localparam logic [15:0] IPR_MASK_FULL = 16'h7777;
    localparam logic [15:0] IPR_MASK_4    = 16'h7077;
    localparam logic [15:0] IPR_RST_FULL  = 16'h4444;
    localparam logic [15:0] IPR_RST_4     = 16'h4044;

    typedef struct packed {
        logic [IPR_ADDR_W-1:0] addr;
        logic [15:0]           wdata;
        logic                  wr;
        logic                  rd;
    } ipr_bus_t;
endpackage : ipr_pkg

// >>> rtl/ipr_regs.sv
// Purpose: priority control registers 4 to 8 with per-source gating
// Assumes: pending flags come from logic on the same clock
// Notes:   level outputs read zero for a disabled source
`timescale 1ns/10ps
module ipr_regs (
    input  wire logic                  clock_i,
    input  wire logic                  sys_rst_i,
    input  wire ipr_pkg::ipr_bus_t     bus_i,
    output logic [15:0]                rdata_o,
    input  wire logic [18:0]           pend_i,
    output logic [18:0]                req_o,
    output logic [56:0]                level_o
);
    // Register state, one word per implemented index
    logic [15:0] r4_q;
    logic [15:0] r5_q;
    logic [15:0] r6_q;
    logic [15:0] r7_q;
    logic [15:0] r8_q;

    // Read path: one registered word, zero outside the read cycle
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic [15:0] rsel;

    // Bus decode
    wire  [15:0] wd      = bus_i.wdata;
    wire         hit4    = bus_i.addr == ipr_pkg::IPR_IDX_CTRL4;
    wire         hit5    = bus_i.addr == ipr_pkg::IPR_IDX_CTRL5;
    wire         hit6    = bus_i.addr == ipr_pkg::IPR_IDX_CTRL6;
    wire         hit7    = bus_i.addr == ipr_pkg::IPR_IDX_CTRL7;
    wire         hit8    = bus_i.addr == ipr_pkg::IPR_IDX_CTRL8;
    wire         hit_any = hit4 || hit5 || hit6 || hit7 || hit8;

    // Write strobes per register
    wire         we4     = bus_i.wr && hit4;
    wire         we5     = bus_i.wr && hit5;
    wire         we6     = bus_i.wr && hit6;
    wire         we7     = bus_i.wr && hit7;
    wire         we8     = bus_i.wr && hit8;

    // Masked write data; reserved positions never reach a flop
    wire  [15:0] wd4     = wd & ipr_pkg::IPR_MASK_4;
    wire  [15:0] wd_full = wd & ipr_pkg::IPR_MASK_FULL;

    // Unmapped indices read zero
    always_comb begin
        if (hit4) begin
            rsel = r4_q;
        end else if (hit5) begin
            rsel = r5_q;
        end else if (hit6) begin
            rsel = r6_q;
        end else if (hit7) begin
            rsel = r7_q;
        end else if (hit8) begin
            rsel = r8_q;
        end else begin
            rsel = 16'h0000;
        end
    end

    // Data stands only the cycle after the strobe, so idle reads show 0
    assign rdata_d = bus_i.rd ? rsel : 16'h0000;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            r4_q <= ipr_pkg::IPR_RST_4;
        end else if (we4) begin
            r4_q <= wd4;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            r5_q <= ipr_pkg::IPR_RST_FULL;
        end else if (we5) begin
            r5_q <= wd_full;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            r6_q <= ipr_pkg::IPR_RST_FULL;
        end else if (we6) begin
            r6_q <= wd_full;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            r7_q <= ipr_pkg::IPR_RST_FULL;
        end else if (we7) begin
            r7_q <= wd_full;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            r8_q <= ipr_pkg::IPR_RST_FULL;
        end else if (we8) begin
            r8_q <= wd_full;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    // Named fields of register 4; bits 11-7 have no storage behind them
    wire  [2:0]  change_notify_level      = r4_q[14:12];
    wire  [2:0]  twowire1_master_level    = r4_q[6:4];
    wire  [2:0]  twowire1_slave_level     = r4_q[2:0];

    // Named fields of register 5
    wire  [2:0]  capture8_level           = r5_q[14:12];
    wire  [2:0]  capture7_level           = r5_q[10:8];
    wire  [2:0]  converter2_done_level    = r5_q[6:4];
    wire  [2:0]  ext_irq1_level           = r5_q[2:0];

    // Named fields of register 6
    wire  [2:0]  timer4_level             = r6_q[14:12];
    wire  [2:0]  compare4_level           = r6_q[10:8];
    wire  [2:0]  compare3_level           = r6_q[6:4];
    wire  [2:0]  xfer_chan2_done_level    = r6_q[2:0];

    // Named fields of register 7
    wire  [2:0]  serial2_tx_level         = r7_q[14:12];
    wire  [2:0]  serial2_rx_level         = r7_q[10:8];
    wire  [2:0]  ext_irq2_level           = r7_q[6:4];
    wire  [2:0]  timer5_level             = r7_q[2:0];

    // Named fields of register 8
    wire  [2:0]  can1_event_level         = r8_q[14:12];
    wire  [2:0]  can1_rx_ready_level      = r8_q[10:8];
    wire  [2:0]  serial_periph2_event_level = r8_q[6:4];
    wire  [2:0]  serial_periph2_error_level = r8_q[2:0];

    // Source order: register 4 high..low, then 5..8 fields high..low
    wire  [56:0] lv = {change_notify_level,
                       twowire1_master_level,
                       twowire1_slave_level,
                       capture8_level,
                       capture7_level,
                       converter2_done_level,
                       ext_irq1_level,
                       timer4_level,
                       compare4_level,
                       compare3_level,
                       xfer_chan2_done_level,
                       serial2_tx_level,
                       serial2_rx_level,
                       ext_irq2_level,
                       timer5_level,
                       can1_event_level,
                       can1_rx_ready_level,
                       serial_periph2_event_level,
                       serial_periph2_error_level};

    // Level equals field code: 1 lowest, 7 highest; ranking is downstream
    assign level_o = lv;

    // Gating only; a zero code must never let a pending flag through
    genvar g;
    generate
        for (g = 0; g < ipr_pkg::IPR_NSRC; g++) begin : g_src
            assign req_o[g] = pend_i[g] &&
                (lv[3*g +: 3] != ipr_pkg::IPR_LVL_OFF);

            off_blocks_a: assert property (@(posedge clock_i)
                disable iff (sys_rst_i)
                (lv[3*g +: 3] == ipr_pkg::IPR_LVL_OFF) |-> !req_o[g])
                else $error("disabled source raised a request");

            req_on_a: assert property (@(posedge clock_i)
                disable iff (sys_rst_i)
                pend_i[g] && lv[3*g +: 3] != ipr_pkg::IPR_LVL_OFF
                |-> req_o[g])
                else $error("enabled source request lost");
        end
    endgenerate

    // Reserved positions stay zero in every register
    gap_zero_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (r4_q & ~ipr_pkg::IPR_MASK_4) == 16'h0000)
        else $error("reserved bit set in register 4");

    res_zero5_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (r5_q & ~ipr_pkg::IPR_MASK_FULL) == 16'h0000)
        else $error("reserved bit set in register 5");

    res_zero6_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (r6_q & ~ipr_pkg::IPR_MASK_FULL) == 16'h0000)
        else $error("reserved bit set in register 6");

    res_zero7_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (r7_q & ~ipr_pkg::IPR_MASK_FULL) == 16'h0000)
        else $error("reserved bit set in register 7");

    res_zero8_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (r8_q & ~ipr_pkg::IPR_MASK_FULL) == 16'h0000)
        else $error("reserved bit set in register 8");

    // Reset loads level four into every field
    rst_val_a: assert property (@(posedge clock_i)
        $past(sys_rst_i) |-> r6_q == ipr_pkg::IPR_RST_FULL)
        else $error("bad reset value in register 6");

    rst_val4_a: assert property (@(posedge clock_i)
        $past(sys_rst_i) |-> r4_q == ipr_pkg::IPR_RST_4)
        else $error("bad reset value in register 4");

    rst_val5_a: assert property (@(posedge clock_i)
        $past(sys_rst_i) |-> r5_q == ipr_pkg::IPR_RST_FULL)
        else $error("bad reset value in register 5");

    rst_val7_a: assert property (@(posedge clock_i)
        $past(sys_rst_i) |-> r7_q == ipr_pkg::IPR_RST_FULL)
        else $error("bad reset value in register 7");

    rst_val8_a: assert property (@(posedge clock_i)
        $past(sys_rst_i) |-> r8_q == ipr_pkg::IPR_RST_FULL)
        else $error("bad reset value in register 8");

    // A write lands in the next cycle, masked
    wr_land_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        we6 |=> r6_q == $past(wd_full))
        else $error("write to register 6 not stored");

    wr_land4_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        we4 |=> r4_q == $past(wd4))
        else $error("write to register 4 not stored");

    // Unmapped index must leave the whole bank untouched
    wr_unmap_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        bus_i.wr && !hit_any |=> $stable(r4_q) && $stable(r5_q)
        && $stable(r6_q) && $stable(r7_q) && $stable(r8_q))
        else $error("unmapped write disturbed the bank");

    // Write then read of the same word returns the masked value
    rd_back_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        we5 && !bus_i.rd ##1 bus_i.rd && hit5
        |=> rdata_o == ($past(wd, 2) & ipr_pkg::IPR_MASK_FULL))
        else $error("readback mismatch in register 5");

    rd_back4_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        we4 && !bus_i.rd ##1 bus_i.rd && hit4
        |=> rdata_o == ($past(wd, 2) & ipr_pkg::IPR_MASK_4))
        else $error("readback mismatch in register 4");

    rd_back8_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        we8 && !bus_i.rd ##1 bus_i.rd && hit8
        |=> rdata_o == ($past(wd, 2) & ipr_pkg::IPR_MASK_FULL))
        else $error("readback mismatch in register 8");

    // Read data stands one cycle only; idle cycles show zero
    rd_idle_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !bus_i.rd |=> rdata_o == 16'h0000)
        else $error("read data outside its cycle");

    // Unmapped reads return zero
    rd_unmap_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        bus_i.rd && !hit_any |=> rdata_o == 16'h0000)
        else $error("unmapped read returned data");
endmodule : ipr_regs

// >>> testbench/ipr_regs_tb.sv
// Purpose: self-checking bench for priority registers 4 to 8
// Assumes: one-cycle strobes, read data the cycle after the read
// Notes:   each task leaves a free edge so strobes never collide
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module ipr_regs_tb;
    logic              clock_i   = 1'b0;
    logic              sys_rst_i = 1'b1;
    ipr_pkg::ipr_bus_t bus_i     = '0;
    logic [15:0]       rdata_o;
    logic [18:0]       pend_i    = 19'h7FFFF;
    logic [18:0]       req_o;
    logic [56:0]       level_o;
    logic [15:0]       cur [5]   = '{16'h4044, 16'h4444, 16'h4444,
                                     16'h4444, 16'h4444};
    logic [15:0]       pat [4]   = '{16'hFFFF, 16'h0000, 16'h1111, 16'h7531};
    int                fail_count = 0;
    int                num_checks = 0;
    ipr_regs u_ipr_regs (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .pend_i(pend_i), .req_o(req_o),
        .level_o(level_o));
    initial forever #2.5 clock_i = ~clock_i;
    task automatic wrap_up;
        if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic acc(input logic [2:0] a, input logic [15:0] d, input logic w);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clock_i);
        bus_i.wr <= 1'b0;
        bus_i.rd <= 1'b0;
        #1;
    endtask : acc
    task automatic chk_regs;
        logic [56:0] l;
        logic [18:0] q;
        for (int a = 0; a < 5; a++) begin
            acc(3'(a), 16'h0000, 1'b0);
            `CHK(rdata_o, cur[a])
        end
        l = {cur[0][14:12], cur[0][6:4], cur[0][2:0]};
        for (int r = 1; r < 5; r++) l = {l[44:0], cur[r][14:12],
            cur[r][10:8], cur[r][6:4], cur[r][2:0]};
        for (int g = 0; g < 19; g++) q[g] = pend_i[g] && (l[3*g+:3] != 3'h0);
        `CHK(level_o, l)
        `CHK(req_o, q)
    endtask : chk_regs
    initial begin
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        chk_regs();
        for (int k = 0; k < 4; k++) begin
            for (int a = 0; a < 5; a++) begin
                acc(3'(a), pat[k] ^ 16'(a), 1'b1);
                cur[a] = (pat[k] ^ 16'(a)) & (a == 0 ? 16'h7077 : 16'h7777);
            end
            chk_regs();
        end
        // Unmapped index must neither store nor disturb the bank
        acc(3'h5, 16'hFFFF, 1'b1);
        acc(3'h5, 16'h0000, 1'b0);
        `CHK(rdata_o, 16'h0000)
        pend_i <= 19'h0;
        chk_regs();
        wrap_up();
    end
    initial begin
        #20000;
        fail_count++;
        wrap_up();
    end
endmodule : ipr_regs_tb
